// >>> core/scrb_link_if.sv
`timescale 1ns/1ps
`include "scrb_params.svh"

interface scrb_link_if;
    // Word assembled on the control clock, read across the crossing.
    logic [`SCRB_WORD_MSB:0] shift_word;

    modport shifter (output shift_word);
    modport core (input shift_word);
endinterface

// >>> core/scrb_params.svh
// Overview of operation
// - Host shifts 16 bits, strobe latches word.
// - Bits B10:B9 select; 00 left, 01 right.
// - Left word: code B7..B0, load B8.
// - Right word: code B7..B0, load B8.
// - Gain is half dB times code minus 255.
// - Code 01 is -127 dB; 00 mutes.
// - Common mode: left code drives both channels.
// - Individual mode: each channel its own code.
// - Left load applies left, refreshes right.
// - Left write without load holds left level.
// - Right load applies right, refreshes left.
// - Right write without load holds right level.
// - Writes accepted only while mode select high.
// - Format, width, rate, polarity, mutes default off.
// - 0 dB individual, 44.1k, bit 16 defaults.
// - Third register field layout B8 down to B0.
// - Fourth register field layout B8 down to B0.
// - Select 10 third register, 11 fourth register.
// - Converter disable forces bipolar zero outputs.
`ifndef SCRB_PARAMS_SVH
`define SCRB_PARAMS_SVH

`define SCRB_WORD_MSB 15
`define SCRB_SEL_HI 10
`define SCRB_SEL_LO 9
`define SCRB_LOAD_BIT 8
`define SCRB_CODE_HI 7
`define SCRB_FIELD_HI 8
`define SCRB_HCP_HI 8
`define SCRB_HCP_LO 7
`define SCRB_GAIN_BIT 6
`define SCRB_RATE_BIT 5
`define SCRB_WID_HI 4
`define SCRB_WID_LO 3
`define SCRB_DIS_BIT 2
`define SCRB_DEM_BIT 1
`define SCRB_MUT_BIT 0
`define SCRB_ZD_BIT 8
`define SCRB_SF_HI 7
`define SCRB_SF_LO 6
`define SCRB_CKO_BIT 5
`define SCRB_INV_BIT 4
`define SCRB_ATC_BIT 2
`define SCRB_LRP_BIT 1
`define SCRB_FMT_BIT 0
`define SCRB_CODE_MAX 8'h00FF
`define SCRB_CODE_MUTE 8'h0000
`define SCRB_FMT_RST 9'h0000
`define SCRB_OUT_RST 9'h0080

`endif

// >>> core/scrb_pkg.sv
package scrb_pkg;

    // Register selected by the two address bits of a control word.
    typedef enum logic [1:0]
    {
        SCRB_REG_LEFT = 2'b00,
        SCRB_REG_RIGHT = 2'b01,
        SCRB_REG_FORMAT = 2'b10,
        SCRB_REG_OUTPUT = 2'b11
    } scrb_reg_e;

    typedef logic [7:0] scrb_code_t;

endpackage

// >>> core/scrb_shifter.sv
`timescale 1ns/1ps
`include "scrb_params.svh"

module scrb_shifter
(
    // Serial link.
    input wire logic control_clock,
    input wire logic control_data,
    // Assembled word.
    scrb_link_if.shifter link
);

    // MSB enters first, so after sixteen clocks the word sits in place.
    // The last sixteen bits count; an overlong burst simply pushes older bits out.
    always_ff @(posedge control_clock)
    begin
        link.shift_word <= {link.shift_word[`SCRB_WORD_MSB-1:0], control_data};
    end

endmodule

// >>> core/scrb_top.sv
`timescale 1ns/1ps
`include "scrb_params.svh"

module scrb_top
    import scrb_pkg::*;
(
    // System clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins of the serial control link.
    input wire logic mode_select,
    input wire logic control_clock,
    input wire logic control_data,
    input wire logic latch_strobe,
    // Applied attenuation per channel.
    output logic [7:0] left_applied_code,
    output logic [7:0] right_applied_code,
    output logic [7:0] left_atten_halfdb,
    output logic [7:0] right_atten_halfdb,
    output logic left_inf_mute,
    output logic right_inf_mute,
    // Format and mute control fields.
    output logic [1:0] hidden_code_pos,
    output logic gain_scaling_sel,
    output logic rate_range_sel,
    output logic [1:0] word_width_sel,
    output logic converter_disable,
    output logic deemph_enable,
    output logic soft_mute_bit,
    // Output and clock control fields.
    output logic zero_detect_mute_en,
    output logic [1:0] deemph_rate_sel,
    output logic clock_out_divide,
    output logic output_invert,
    output logic common_atten_select,
    output logic frame_polarity_sel,
    output logic audio_format_sel,
    output logic force_bipolar_zero
);

    scrb_link_if link ();

    logic strobe_s1;
    logic strobe_s2;
    logic strobe_s3;
    logic mode_s1;
    logic mode_s2;
    logic [`SCRB_WORD_MSB:0] word_s1;
    logic [`SCRB_WORD_MSB:0] word_s2;
    logic latch_edge;
    logic write_en;
    scrb_reg_e reg_sel;
    logic load_bit;
    scrb_code_t new_code;
    scrb_code_t left_code;
    scrb_code_t right_code;
    scrb_code_t next_left_applied;
    scrb_code_t next_right_applied;
    logic [`SCRB_FIELD_HI:0] fmt_field;
    logic [`SCRB_FIELD_HI:0] out_field;
    logic [`SCRB_FIELD_HI:0] next_fmt_field;
    logic [`SCRB_FIELD_HI:0] next_out_field;

    // The shift register runs on the host's clock, which stops between words.
    scrb_shifter u_shifter
    (
        .control_clock(control_clock),
        .control_data(control_data),
        .link(link.shifter)
    );

    // Strobe and mode pins pass two flip-flops before any logic sees them.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            strobe_s1 <= 1'b0;
            strobe_s2 <= 1'b0;
            strobe_s3 <= 1'b0;
            mode_s1 <= 1'b0;
            mode_s2 <= 1'b0;
        end
        else
        begin
            strobe_s1 <= latch_strobe;
            strobe_s2 <= strobe_s1;
            strobe_s3 <= strobe_s2;
            mode_s1 <= mode_select;
            mode_s2 <= mode_s1;
        end
    end

    // The word is quasi-static once the host stops clocking, so it is
    // simply resynchronised; it has settled long before the strobe edge
    // emerges from its own two stages.
    always_ff @(posedge sys_clk)
    begin
        word_s1 <= link.shift_word;
        word_s2 <= word_s1;
    end

    // Rising strobe commits the assembled word; software mode gates it.
    assign latch_edge = strobe_s2 & ~strobe_s3;
    assign write_en = latch_edge & mode_s2;

    // Address decode ignores the reserved top bits entirely.
    assign reg_sel = scrb_reg_e'(word_s2[`SCRB_SEL_HI:`SCRB_SEL_LO]);
    assign load_bit = word_s2[`SCRB_LOAD_BIT];
    assign new_code = word_s2[`SCRB_CODE_HI:0];

    // Latest programmed codes, kept even when no load is requested.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            left_code <= `SCRB_CODE_MAX;
            right_code <= `SCRB_CODE_MAX;
        end
        else if (write_en)
        begin
            if (reg_sel == SCRB_REG_LEFT)
            begin
                left_code <= new_code;
            end
            if (reg_sel == SCRB_REG_RIGHT)
            begin
                right_code <= new_code;
            end
        end
    end

    // Applied levels change only on a write that carries its load bit.
    // Common mode is taken from the current fourth register at load time.
    always_comb
    begin
        next_left_applied = left_applied_code;
        next_right_applied = right_applied_code;
        if (write_en && load_bit && reg_sel == SCRB_REG_LEFT)
        begin
            next_left_applied = new_code;
            if (common_atten_select)
            begin
                next_right_applied = new_code;
            end
            else
            begin
                next_right_applied = right_code;
            end
        end
        else if (write_en && load_bit && reg_sel == SCRB_REG_RIGHT)
        begin
            next_left_applied = left_code;
            if (common_atten_select)
            begin
                next_right_applied = left_code;
            end
            else
            begin
                next_right_applied = new_code;
            end
        end
        // A write with the load bit clear falls through and holds.
    end

    // Applied codes and their attenuation in half-dB steps (255 minus code).
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            left_applied_code <= `SCRB_CODE_MAX;
            right_applied_code <= `SCRB_CODE_MAX;
            left_atten_halfdb <= `SCRB_CODE_MAX - `SCRB_CODE_MAX;
            right_atten_halfdb <= `SCRB_CODE_MAX - `SCRB_CODE_MAX;
            left_inf_mute <= 1'b0;
            right_inf_mute <= 1'b0;
        end
        else
        begin
            left_applied_code <= next_left_applied;
            right_applied_code <= next_right_applied;
            left_atten_halfdb <= `SCRB_CODE_MAX - next_left_applied;
            right_atten_halfdb <= `SCRB_CODE_MAX - next_right_applied;
            left_inf_mute <= (next_left_applied == `SCRB_CODE_MUTE);
            right_inf_mute <= (next_right_applied == `SCRB_CODE_MUTE);
        end
    end

    // Next contents of the two control registers.
    always_comb
    begin
        next_fmt_field = fmt_field;
        next_out_field = out_field;
        if (write_en && reg_sel == SCRB_REG_FORMAT)
        begin
            next_fmt_field = word_s2[`SCRB_FIELD_HI:0];
        end
        if (write_en && reg_sel == SCRB_REG_OUTPUT)
        begin
            next_out_field = word_s2[`SCRB_FIELD_HI:0];
        end
    end

    // Control registers with their power-up defaults.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            fmt_field <= `SCRB_FMT_RST;
            out_field <= `SCRB_OUT_RST;
        end
        else
        begin
            fmt_field <= next_fmt_field;
            out_field <= next_out_field;
        end
    end

    // Field outputs are registered copies so each comes from a flip-flop.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            hidden_code_pos <= 2'(`SCRB_FMT_RST >> `SCRB_HCP_LO);
            gain_scaling_sel <= 1'b0;
            rate_range_sel <= 1'b0;
            word_width_sel <= 2'b00;
            converter_disable <= 1'b0;
            deemph_enable <= 1'b0;
            soft_mute_bit <= 1'b0;
            force_bipolar_zero <= 1'b0;
        end
        else
        begin
            hidden_code_pos <= next_fmt_field[`SCRB_HCP_HI:`SCRB_HCP_LO];
            gain_scaling_sel <= next_fmt_field[`SCRB_GAIN_BIT];
            rate_range_sel <= next_fmt_field[`SCRB_RATE_BIT];
            word_width_sel <= next_fmt_field[`SCRB_WID_HI:`SCRB_WID_LO];
            converter_disable <= next_fmt_field[`SCRB_DIS_BIT];
            deemph_enable <= next_fmt_field[`SCRB_DEM_BIT];
            soft_mute_bit <= next_fmt_field[`SCRB_MUT_BIT];
            // Disable overrides every audio input, so it is exported as its own flag.
            force_bipolar_zero <= next_fmt_field[`SCRB_DIS_BIT];
        end
    end

    // Fourth register fields; the reserved bit is stored but drives nothing.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            zero_detect_mute_en <= 1'b0;
            deemph_rate_sel <= 2'(`SCRB_OUT_RST >> `SCRB_SF_LO);
            clock_out_divide <= 1'b0;
            output_invert <= 1'b0;
            common_atten_select <= 1'b0;
            frame_polarity_sel <= 1'b0;
            audio_format_sel <= 1'b0;
        end
        else
        begin
            zero_detect_mute_en <= next_out_field[`SCRB_ZD_BIT];
            deemph_rate_sel <= next_out_field[`SCRB_SF_HI:`SCRB_SF_LO];
            clock_out_divide <= next_out_field[`SCRB_CKO_BIT];
            output_invert <= next_out_field[`SCRB_INV_BIT];
            common_atten_select <= next_out_field[`SCRB_ATC_BIT];
            frame_polarity_sel <= next_out_field[`SCRB_LRP_BIT];
            audio_format_sel <= next_out_field[`SCRB_FMT_BIT];
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // A committed third-register word shows up on the outputs next cycle.
    a_commit_format: assert property (
        write_en && reg_sel == SCRB_REG_FORMAT |=>
            soft_mute_bit == $past(word_s2[`SCRB_MUT_BIT]) &&
            word_width_sel == $past(word_s2[`SCRB_WID_HI:`SCRB_WID_LO]) &&
            hidden_code_pos == $past(word_s2[`SCRB_HCP_HI:`SCRB_HCP_LO]))
        else $error("format register did not take the latched word");

    // The edge detector fires one clock after the first stage rises.
    a_strobe_latency: assert property (
        $rose(strobe_s1) && mode_s1 && mode_s2 |=> write_en)
        else $error("strobe edge not turned into a write");

    a_left_store: assert property (
        write_en && reg_sel == SCRB_REG_LEFT |=> left_code == $past(new_code))
        else $error("left code not stored");

    a_right_store: assert property (
        write_en && reg_sel == SCRB_REG_RIGHT |=>
            right_code == $past(new_code) && $stable(left_code))
        else $error("right code not stored");

    a_gain_map: assert property (
        left_atten_halfdb == `SCRB_CODE_MAX - left_applied_code &&
            right_atten_halfdb == `SCRB_CODE_MAX - right_applied_code)
        else $error("attenuation steps do not match the code");

    a_mute_code: assert property (
        left_inf_mute == (left_applied_code == `SCRB_CODE_MUTE) &&
            right_inf_mute == (right_applied_code == `SCRB_CODE_MUTE))
        else $error("infinite mute does not follow code zero");

    a_common_load: assert property (
        write_en && load_bit && reg_sel == SCRB_REG_LEFT && common_atten_select |=>
            left_applied_code == $past(new_code) && right_applied_code == $past(new_code))
        else $error("common left load did not set both channels");

    a_indiv_load: assert property (
        write_en && load_bit && reg_sel == SCRB_REG_RIGHT && !common_atten_select |=>
            right_applied_code == $past(new_code) && left_applied_code == $past(left_code))
        else $error("individual right load applied wrong codes");

    a_left_hold: assert property (
        write_en && !load_bit && reg_sel == SCRB_REG_LEFT |=>
            $stable(left_applied_code) && $stable(right_applied_code))
        else $error("left write without load changed a level");

    a_right_hold: assert property (
        write_en && !load_bit && reg_sel == SCRB_REG_RIGHT |=>
            $stable(right_applied_code) && $stable(left_applied_code))
        else $error("right write without load changed a level");

    a_mode_gate: assert property (
        latch_edge && !mode_s2 |=>
            $stable(fmt_field) && $stable(out_field) && $stable(left_code) && $stable(right_code))
        else $error("write accepted in hardware mode");

    // Reset itself is the trigger here, so the default disable must not apply.
    a_reset_dflt: assert property (@(posedge sys_clk) disable iff (1'b0)
        !rst_n |=> deemph_rate_sel == 2'b10 && left_applied_code == `SCRB_CODE_MAX &&
            !common_atten_select && !soft_mute_bit && !converter_disable && word_width_sel == 2'b00)
        else $error("reset defaults wrong");

    a_output_fields: assert property (
        write_en && reg_sel == SCRB_REG_OUTPUT |=>
            common_atten_select == $past(word_s2[`SCRB_ATC_BIT]) &&
            zero_detect_mute_en == $past(word_s2[`SCRB_ZD_BIT]) &&
            deemph_rate_sel == $past(word_s2[`SCRB_SF_HI:`SCRB_SF_LO]))
        else $error("output register fields misplaced");

    // Checked against the committed word, not against the sibling output.
    a_bipolar_zero: assert property (
        write_en && reg_sel == SCRB_REG_FORMAT |=> force_bipolar_zero == $past(word_s2[`SCRB_DIS_BIT]))
        else $error("disable does not force bipolar zero");

    c_common_load: cover property (
        write_en && load_bit && reg_sel == SCRB_REG_LEFT && common_atten_select);
    c_right_load: cover property (
        write_en && load_bit && reg_sel == SCRB_REG_RIGHT && !common_atten_select);
    c_mode_block: cover property (latch_edge && !mode_s2);
    c_mute_code: cover property ($rose(left_inf_mute));

endmodule

// >>> verification/scrb_host_model.sv
`timescale 1ns/1ps

module scrb_host_model
(
    // Request side; the bench drives all but busy.
    input wire logic sys_clk,
    input wire logic req,
    input wire logic [15:0] word,
    output logic busy,
    // Serial control link pins.
    output logic control_clock,
    output logic control_data,
    output logic latch_strobe
);
    // One frame per request: the link clock runs at 12 ns only inside the frame and stands still between frames.
    initial
    begin
        control_clock = 1'b0;
        control_data = 1'b0;
        latch_strobe = 1'b0;
        busy = 1'b0;
        forever
        begin
            @(posedge sys_clk);
            if (req === 1'b1)
            begin
                busy <= 1'b1;
                // Most significant bit first, one bit for each rising link clock.
                for (int i = 15; i >= 0; i--)
                begin
                    #1 control_data = word[i];
                    #5 control_clock = 1'b1;
                    #6 control_clock = 1'b0;
                end
                // The strobe rises only after the sixteenth bit and is held long enough to pass two flops.
                repeat (2) @(posedge sys_clk);
                latch_strobe <= 1'b1;
                repeat (4) @(posedge sys_clk);
                latch_strobe <= 1'b0;
                // The data line has no pull, so show the inverse once its hold has run out.
                control_data <= ~control_data;
                repeat (4) @(posedge sys_clk);
                busy <= 1'b0;
            end
        end
    end
endmodule

// >>> verification/serial_control_register_bank_tb.sv
`timescale 1ns/1ps

module serial_control_register_bank_tb
    import scrb_pkg::*;
;
    // Bench side of the link and the counters.
    logic sys_clk;
    logic rst_n;
    logic mode_select;
    logic req;
    logic busy;
    logic [15:0] word;
    logic control_clock;
    logic control_data;
    logic latch_strobe;
    int mismatches;
    int num_checks;
    // Design outputs.
    logic [7:0] left_applied_code;
    logic [7:0] right_applied_code;
    logic [7:0] left_atten_halfdb;
    logic [7:0] right_atten_halfdb;
    logic left_inf_mute;
    logic right_inf_mute;
    logic [1:0] hidden_code_pos;
    logic gain_scaling_sel;
    logic rate_range_sel;
    logic [1:0] word_width_sel;
    logic converter_disable;
    logic deemph_enable;
    logic soft_mute_bit;
    logic zero_detect_mute_en;
    logic [1:0] deemph_rate_sel;
    logic clock_out_divide;
    logic output_invert;
    logic common_atten_select;
    logic frame_polarity_sel;
    logic audio_format_sel;
    logic force_bipolar_zero;
    logic [8:0] fmt_bus;
    logic [7:0] out_bus;
    logic [8:0] v;

    // Field outputs packed in register bit order; the reserved bit of the fourth register has no output.
    assign fmt_bus = {hidden_code_pos, gain_scaling_sel, rate_range_sel, word_width_sel, converter_disable,
                      deemph_enable, soft_mute_bit};
    assign out_bus = {zero_detect_mute_en, deemph_rate_sel, clock_out_divide, output_invert,
                      common_atten_select, frame_polarity_sel, audio_format_sel};

    scrb_host_model host
    (
        .sys_clk(sys_clk),
        .req(req),
        .word(word),
        .busy(busy),
        .control_clock(control_clock),
        .control_data(control_data),
        .latch_strobe(latch_strobe)
    );

    scrb_top DUT
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .mode_select(mode_select),
        .control_clock(control_clock),
        .control_data(control_data),
        .latch_strobe(latch_strobe),
        .left_applied_code(left_applied_code),
        .right_applied_code(right_applied_code),
        .left_atten_halfdb(left_atten_halfdb),
        .right_atten_halfdb(right_atten_halfdb),
        .left_inf_mute(left_inf_mute),
        .right_inf_mute(right_inf_mute),
        .hidden_code_pos(hidden_code_pos),
        .gain_scaling_sel(gain_scaling_sel),
        .rate_range_sel(rate_range_sel),
        .word_width_sel(word_width_sel),
        .converter_disable(converter_disable),
        .deemph_enable(deemph_enable),
        .soft_mute_bit(soft_mute_bit),
        .zero_detect_mute_en(zero_detect_mute_en),
        .deemph_rate_sel(deemph_rate_sel),
        .clock_out_divide(clock_out_divide),
        .output_invert(output_invert),
        .common_atten_select(common_atten_select),
        .frame_polarity_sel(frame_polarity_sel),
        .audio_format_sel(audio_format_sel),
        .force_bipolar_zero(force_bipolar_zero)
    );

    // System clock of 10 ns.
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Case equality, so an unknown output never passes.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Address bits sit at B10:B9 and reserved bits are always sent low.
    function automatic logic [15:0] mk(input scrb_reg_e sel, input logic [8:0] f);
        return {5'h00, sel, f};
    endfunction

    // Hands one word to the host model and waits, bounded, until its frame and strobe are done.
    task automatic write_word(input logic [15:0] w);
        int n;
        n = 0;
        @(posedge sys_clk);
        word <= w;
        req <= 1'b1;
        while (busy !== 1'b1 && n < 50)
        begin
            @(posedge sys_clk);
            n++;
        end
        req <= 1'b0;
        // A model that never started must not look like a finished frame.
        if (busy !== 1'b1)
        begin
            n = 300;
        end
        while (busy !== 1'b0 && n < 300)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 300)
        begin
            mismatches++;
            tally_and_finish();
        end
    endtask

    // Applied codes, half-dB figures and infinite mute flags of both channels.
    task automatic check_levels(input logic [7:0] l, input logic [7:0] r);
        check({left_applied_code, right_applied_code}, {l, r});
        check({left_atten_halfdb, right_atten_halfdb}, {8'hFF - l, 8'hFF - r});
        check({14'h0000, left_inf_mute, right_inf_mute}, {14'h0000, l == 8'h00, r == 8'h00});
    endtask

    // Reset state: 0 dB, every field clear except the de-emphasis rate.
    task automatic check_defaults;
        check_levels(8'hFF, 8'hFF);
        check({6'h00, force_bipolar_zero, fmt_bus}, 16'h0000);
        check({8'h00, out_bus}, 16'h0040);
    endtask

    // Main sequence.
    initial
    begin
        rst_n = 1'b0;
        mode_select = 1'b1;
        req = 1'b0;
        word = 16'h0000;
        mismatches = 0;
        num_checks = 0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        check_defaults();
        // Individual mode: stores without load, loads refresh the other channel from its stored code.
        write_word(mk(SCRB_REG_LEFT, 9'h012));
        check_levels(8'hFF, 8'hFF);
        write_word(mk(SCRB_REG_RIGHT, 9'h134));
        check_levels(8'h12, 8'h34);
        write_word(mk(SCRB_REG_RIGHT, 9'h056));
        check_levels(8'h12, 8'h34);
        write_word(mk(SCRB_REG_LEFT, 9'h100));
        check_levels(8'h00, 8'h56);
        write_word(mk(SCRB_REG_LEFT, 9'h101));
        check_levels(8'h01, 8'h56);
        // Walk a single one through each field of the two control registers.
        for (int b = 0; b < 9; b++)
        begin
            v = 9'h001 << b;
            write_word(mk(SCRB_REG_FORMAT, v));
            check({6'h00, force_bipolar_zero, fmt_bus}, {6'h00, v[2], v});
        end
        for (int b = 0; b < 9; b++)
        begin
            v = 9'h001 << b;
            write_word(mk(SCRB_REG_OUTPUT, v));
            check({8'h00, out_bus}, {8'h00, v[8:4], v[2:0]});
        end
        // Common mode: the left code drives both channels and the right code is ignored.
        write_word(mk(SCRB_REG_OUTPUT, 9'h004));
        write_word(mk(SCRB_REG_RIGHT, 9'h177));
        check_levels(8'h01, 8'h01);
        write_word(mk(SCRB_REG_LEFT, 9'h188));
        check_levels(8'h88, 8'h88);
        write_word(mk(SCRB_REG_OUTPUT, 9'h000));
        write_word(mk(SCRB_REG_LEFT, 9'h188));
        check_levels(8'h88, 8'h77);
        // Hardware mode: a full frame and strobe must change nothing.
        @(posedge sys_clk);
        mode_select <= 1'b0;
        repeat (4) @(posedge sys_clk);
        write_word(mk(SCRB_REG_LEFT, 9'h199));
        check_levels(8'h88, 8'h77);
        mode_select <= 1'b1;
        repeat (4) @(posedge sys_clk);
        // A second reset in mid-run restores every default, then writes work again.
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        check_defaults();
        write_word(mk(SCRB_REG_LEFT, 9'h140));
        check_levels(8'h40, 8'hFF);
        tally_and_finish();
    end
endmodule
